/* rtl/sam_alert_mask_bank.sv */
// Status alert mask bank: mask storage, command decode and alert gating
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// What this block does
// (R1) Mask bit 0 lets its status bit raise alert; 1 blocks it.
// (R2) Masks never touch status bits; they only gate the alert path.
// (R3) Selector 7Ah picks the output-voltage mask.
// (R4) Command 1Bh shared; 7Bh output-current mask, 7Ch input mask.
// (R5) Selector 7Dh temperature mask, 7Eh communication/memory/logic mask.
// (R6) Host updates a mask with a word write to command 1Bh.
// (R7) Write word low byte is selector, high byte is new mask.
// (R8) Readback is a process call returning the selected mask byte.
// (R9) Readback writes one-byte selector block, answers one-byte mask block.
// (R10) Masks usable only while phase selection equals FFh.
// (R11) Reset values come from stored copy; writes act at once.
// (R12) Output-voltage mask bits 7..2 gate six conditions; bits 1:0 read 00b.
// (R13) Output-current mask bits 7,5,4 gate; others gate nothing.
// (R14) Input mask bits 7..5 writable resetting 0, bit 3 low input.
// (R15) Temperature mask bits 7,6 gate; bits 5:0 read zero.
// (R16) Comm mask bits 7,6,5,4,3,1 gate; bits 2,0 read zero.
// (R17) After the load, alert active while any unmasked status bit set; read-only bits ignore writes.
module sam_alert_mask_bank
  import sam_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_cmd_is_read,
  input wire logic [7:0] i_cmd_lo,
  input wire logic [7:0] i_cmd_hi,
  input wire logic [7:0] i_phase,
  input wire logic [39:0] i_nvm_masks,
  input wire logic [7:0] i_status_vout,
  input wire logic [7:0] i_status_iout,
  input wire logic [7:0] i_status_input,
  input wire logic [7:0] i_status_temp,
  input wire logic [7:0] i_status_cml,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_count,
  output logic [7:0] o_rsp_data,
  output logic o_cmd_reject,
  output logic o_alert_n
);

  //////////////////////////////////////////////////////////////////////////
  // Selector decode, shared by the write, read and refusal paths
  function automatic logic [2:0] sel_to_idx(input logic [7:0] sel);
    case (sel)
      SAM_SEL_VOUT: sel_to_idx = SAM_IDX_VOUT; // [R3]
      SAM_SEL_IOUT: sel_to_idx = SAM_IDX_IOUT; // [R4]
      SAM_SEL_INPUT: sel_to_idx = SAM_IDX_INPUT; // [R4]
      SAM_SEL_TEMP: sel_to_idx = SAM_IDX_TEMP; // [R5]
      SAM_SEL_CML: sel_to_idx = SAM_IDX_CML; // [R5]
      default: sel_to_idx = SAM_IDX_NONE;
    endcase
  endfunction

  // Writable positions per class; read-only bits are cut on every write
  function automatic logic [7:0] idx_wmask(input logic [2:0] idx);
    case (idx)
      SAM_IDX_VOUT: idx_wmask = SAM_WMASK_VOUT; // [R12]
      SAM_IDX_IOUT: idx_wmask = SAM_WMASK_IOUT; // [R13]
      SAM_IDX_INPUT: idx_wmask = SAM_WMASK_INPUT; // [R14]
      SAM_IDX_TEMP: idx_wmask = SAM_WMASK_TEMP; // [R15]
      SAM_IDX_CML: idx_wmask = SAM_WMASK_CML; // [R16]
      default: idx_wmask = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Commands stay refused until every class holds its stored copy
  typedef enum logic [1:0] {ST_LOAD, ST_RUN} sam_state_t;
  sam_state_t state_reg;

  logic [2:0] sel_idx;
  logic sel_ok;
  logic phase_ok;
  logic accept;
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [2:0] load_idx_reg;
  logic [7:0] rd_word;
  logic [39:0] mask_all;
  logic rd_pend_reg;
  logic [2:0] rd_idx_reg;
  logic [39:0] status_all;
  logic [39:0] effective_mask;
  logic alert_reg;

  assign sel_idx = sel_to_idx(i_cmd_lo);
  assign sel_ok = (sel_idx != SAM_IDX_NONE);
  assign phase_ok = (i_phase == SAM_PHASE_ALL); // [R10]
  // Other command codes are left alone: no refusal and no answer
  assign accept = i_cmd_valid && (i_cmd_code == SAM_CMD_MASK) && sel_ok && phase_ok
                  && (state_reg == ST_RUN); // [R6]

  //////////////////////////////////////////////////////////////////////////
  // After reset, copy stored defaults one class per cycle before serving
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state_reg <= ST_LOAD;
      load_idx_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        ST_LOAD:
        begin
          if (load_idx_reg == 3'(SAM_NUM_CLASS - 1))
            state_reg <= ST_RUN;
          load_idx_reg <= load_idx_reg + SAM_LOAD_CYCLES;
        end
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_LOAD;
      endcase
    end
  end

  always_comb
  begin
    mem_we = 1'b0;
    mem_waddr = 3'h0;
    mem_wdata = 8'h00;
    if (state_reg == ST_LOAD)
    begin
      mem_we = 1'b1;
      mem_waddr = load_idx_reg;
      mem_wdata = i_nvm_masks[load_idx_reg*8 +: 8] & idx_wmask(load_idx_reg); // [R11]
      // Input bits 7..5 restart cleared whatever the stored copy holds
      if (load_idx_reg == SAM_IDX_INPUT)
        mem_wdata = mem_wdata & ~SAM_INPUT_ZERO_RST; // [R14]
    end
    else if (accept && !i_cmd_is_read)
    begin
      mem_we = 1'b1; // [R11]
      mem_waddr = sel_idx;
      mem_wdata = i_cmd_hi & idx_wmask(sel_idx); // [R7] [R17]
    end
  end

  // Read port follows the selector every cycle; only a taken read uses it
  sam_mask_mem u_mem (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(sel_idx),
    .o_rdata(rd_word),
    .o_all(mask_all)
  );

  //////////////////////////////////////////////////////////////////////////
  // Readback answer two cycles after the request, a one-byte block
  // Registered data path costs a cycle but keeps the answer glitch-free
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      rd_pend_reg <= 1'b0;
      rd_idx_reg <= 3'h0;
    end
    else
    begin
      rd_pend_reg <= accept && i_cmd_is_read; // [R8]
      // Selector kept so read-only bits are cleared on the way out
      rd_idx_reg <= sel_idx;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_count <= 8'h00;
      o_rsp_data <= 8'h00;
    end
    else
    begin
      o_rsp_valid <= rd_pend_reg;
      o_rsp_count <= rd_pend_reg ? 8'h01 : 8'h00; // [R9]
      o_rsp_data <= rd_pend_reg ? (rd_word & idx_wmask(rd_idx_reg)) : 8'h00; // [R8] [R12]
    end
  end

  // Refusal pulse: bad selector, wrong phase, or still loading
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      o_cmd_reject <= 1'b0;
    else
      o_cmd_reject <= i_cmd_valid && (i_cmd_code == SAM_CMD_MASK) && !accept; // [R10]
  end

  //////////////////////////////////////////////////////////////////////////
  // Status is read only here, never written: masking leaves it untouched
  assign status_all = {i_status_cml, i_status_temp, i_status_input, i_status_iout, i_status_vout}; // [R2]

  // Unimplemented positions count as masked so they can never raise alert
  genvar c;
  generate
    for (c = 0; c < SAM_NUM_CLASS; c++)
    begin : g_gate
      assign effective_mask[c*8 +: 8] = mask_all[c*8 +: 8] | ~idx_wmask(3'(c)); // [R13] [R15] [R16]
    end
  endgenerate

  // Held inactive during the load so stale zeros cannot cause a glitch
  // One cycle of latency from status to pin, traded for a clean output
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      alert_reg <= 1'b0;
    else
      alert_reg <= (state_reg == ST_RUN) && |(status_all & ~effective_mask); // [R1] [R17]
  end

  assign o_alert_n = ~alert_reg;
endmodule

/* rtl/sam_pkg.sv */
// Package: constants for the status alert mask bank
package sam_pkg;
  localparam logic [7:0] SAM_CMD_MASK = 8'h1B;
  localparam logic [7:0] SAM_SEL_VOUT = 8'h7A;
  localparam logic [7:0] SAM_SEL_IOUT = 8'h7B;
  localparam logic [7:0] SAM_SEL_INPUT = 8'h7C;
  localparam logic [7:0] SAM_SEL_TEMP = 8'h7D;
  localparam logic [7:0] SAM_SEL_CML = 8'h7E;
  localparam logic [7:0] SAM_PHASE_ALL = 8'hFF;
  localparam int SAM_NUM_CLASS = 5;
  localparam logic [2:0] SAM_IDX_VOUT = 3'h0;
  localparam logic [2:0] SAM_IDX_IOUT = 3'h1;
  localparam logic [2:0] SAM_IDX_INPUT = 3'h2;
  localparam logic [2:0] SAM_IDX_TEMP = 3'h3;
  localparam logic [2:0] SAM_IDX_CML = 3'h4;
  localparam logic [2:0] SAM_IDX_NONE = 3'h7;
  // Writable bit positions per class
  localparam logic [7:0] SAM_WMASK_VOUT = 8'hFC;
  localparam logic [7:0] SAM_WMASK_IOUT = 8'hB0;
  localparam logic [7:0] SAM_WMASK_INPUT = 8'hE8;
  localparam logic [7:0] SAM_WMASK_TEMP = 8'hC0;
  localparam logic [7:0] SAM_WMASK_CML = 8'hFA;
  // Bits of the input class that reset to zero regardless of stored copy
  localparam logic [7:0] SAM_INPUT_ZERO_RST = 8'hE0;
  localparam logic [2:0] SAM_LOAD_CYCLES = 3'h1;
endpackage

/* rtl/sam_mask_mem.sv */
// Small register memory holding the five mask bytes
`timescale 1ns/1ps
module sam_mask_mem
  import sam_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [2:0] i_raddr,
  output logic [7:0] o_rdata,
  output logic [39:0] o_all
);
  logic [7:0] mem_reg [SAM_NUM_CLASS];

  genvar g;
  generate
    for (g = 0; g < SAM_NUM_CLASS; g++)
    begin : g_word
      always_ff @(posedge i_mclk)
      begin
        if (i_srst)
          mem_reg[g] <= 8'h00;
        else if (i_we && (i_waddr == 3'(g)))
          mem_reg[g] <= i_wdata;
      end
      assign o_all[g*8 +: 8] = mem_reg[g];
    end
  endgenerate

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      o_rdata <= 8'h00;
    else if (i_raddr < 3'(SAM_NUM_CLASS))
      o_rdata <= mem_reg[i_raddr];
    else
      o_rdata <= 8'h00;
  end
endmodule

/* tb/sam_asserts.sv */
// Checker for mask command answers
`timescale 1ns/1ps
module sam_asserts
  import sam_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_cmd_is_read,
  input wire logic [7:0] i_cmd_lo,
  input wire logic [7:0] i_phase,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_count,
  input wire logic [7:0] o_rsp_data,
  input wire logic o_cmd_reject
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic cmd;
  logic sel_ok;
  logic good;
  assign cmd = i_cmd_valid && i_cmd_code == SAM_CMD_MASK;
  assign sel_ok = i_cmd_lo inside {[8'h7A:8'h7E]};
  assign good = cmd && sel_ok && i_phase == 8'hFF;
  // Five load edges must pass before a command is taken
  property p_rd; (!i_srst) [*5] ##1 (good && i_cmd_is_read) |-> ##2 o_rsp_valid; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_ok; (!i_srst) [*5] ##1 good |=> !o_cmd_reject; endproperty
  a_ok: assert property (p_ok) else $error("refused");
  property p_ph; cmd && i_phase != 8'hFF |=> o_cmd_reject; endproperty
  a_ph: assert property (p_ph) else $error("phase taken");
  property p_sel; cmd && !sel_ok |=> o_cmd_reject; endproperty
  a_sel: assert property (p_sel) else $error("selector taken");
  property p_cnt; o_rsp_valid |-> o_rsp_count == 8'h01; endproperty
  a_cnt: assert property (p_cnt) else $error("count");
  property p_idle; !o_rsp_valid |-> o_rsp_count == 8'h00 && o_rsp_data == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_vo; o_rsp_valid && $past(i_cmd_lo, 2) == 8'h7A |-> o_rsp_data[1:0] == 2'h0; endproperty
  a_vo: assert property (p_vo) else $error("vout low bits");
  property p_tp; o_rsp_valid && $past(i_cmd_lo, 2) == 8'h7D |-> o_rsp_data[5:0] == 6'h00; endproperty
  a_tp: assert property (p_tp) else $error("temp low bits");
endmodule
bind sam_alert_mask_bank sam_asserts chk (.*);

/* tb/sam_host_model.sv */
// Bus host model issuing mask commands
`timescale 1ns/1ps
module sam_host_model
(
  input wire logic i_mclk,
  input wire logic i_rsp_valid,
  input wire logic [7:0] i_rsp_data,
  input wire logic i_cmd_reject,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic o_cmd_is_read,
  output logic [7:0] o_cmd_lo,
  output logic [7:0] o_cmd_hi
);
  initial {o_cmd_valid, o_cmd_code, o_cmd_is_read, o_cmd_lo, o_cmd_hi} = 26'h0;
  // Kind 1 is an answer, 2 a refusal
  task automatic xfer(input logic [7:0] code, input logic r, input logic [7:0] lo, input logic [7:0] hi,
    output logic [1:0] kind, output logic [7:0] d);
    kind = 2'h0;
    d = 8'h00;
    @(negedge i_mclk);
    {o_cmd_valid, o_cmd_code, o_cmd_is_read, o_cmd_lo, o_cmd_hi} = {1'b1, code, r, lo, hi};
    @(negedge i_mclk);
    // Released bytes show inverted data, never the stale value
    {o_cmd_valid, o_cmd_lo, o_cmd_hi} = {1'b0, ~lo, ~hi};
    for (int i = 0; i < 4; i++)
    begin
      if (kind == 2'h0 && i_rsp_valid === 1'b1)
        {kind, d} = {2'h1, i_rsp_data};
      if (kind == 2'h0 && i_cmd_reject === 1'b1)
        kind = 2'h2;
      @(negedge i_mclk);
    end
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the status alert mask bank
`timescale 1ns/1ps
module tb_top;
  import sam_pkg::*;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic cv, rd, rv, rj, an;
  logic [7:0] cc, lo, hi, rc, rdat;
  logic [7:0] ph = 8'hFF;
  logic [39:0] nvm = 40'hFF_FF_FF_FF_FF;
  logic [7:0] st [5] = '{default: 8'h00};
  logic [1:0] kind;
  logic [7:0] d;
  int n_fail = 0;
  int total_checks = 0;
  // Selector, written value, expected readback
  logic [23:0] rows [7] = '{24'h7A_FF_FC, 24'h7B_00_00, 24'h7B_FF_B0, 24'h7C_FF_E8, 24'h7D_FF_C0,
    24'h7E_FF_FA, 24'h7A_00_00};
  always #2.5 i_mclk = ~i_mclk;
  sam_host_model host (.i_mclk(i_mclk), .i_rsp_valid(rv), .i_rsp_data(rdat), .i_cmd_reject(rj),
    .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_is_read(rd), .o_cmd_lo(lo), .o_cmd_hi(hi));
  sam_alert_mask_bank dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_cmd_valid(cv), .i_cmd_code(cc),
    .i_cmd_is_read(rd), .i_cmd_lo(lo), .i_cmd_hi(hi), .i_phase(ph), .i_nvm_masks(nvm),
    .i_status_vout(st[0]), .i_status_iout(st[1]), .i_status_input(st[2]), .i_status_temp(st[3]),
    .i_status_cml(st[4]), .o_rsp_valid(rv), .o_rsp_count(rc), .o_rsp_data(rdat), .o_cmd_reject(rj),
    .o_alert_n(an));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [7:0] code, input logic r, input logic [7:0] sel, input logic [7:0] v,
    input logic [1:0] k, input logic [7:0] e);
    host.xfer(code, r, sel, v, kind, d);
    chk({6'h00, kind}, {6'h00, k});
    chk(d, e);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge i_mclk);
    i_srst = 1'b0;
    go(8'h1B, 1'b1, 8'h7A, 8'h00, 2'h2, 8'h00);
    go(8'h1B, 1'b1, 8'h7C, 8'h00, 2'h1, 8'h08);
    go(8'h1B, 1'b1, 8'h7A, 8'h00, 2'h1, 8'hFC);
    foreach (rows[i])
    begin
      go(8'h1B, 1'b0, rows[i][23:16], rows[i][15:8], 2'h0, 8'h00);
      go(8'h1B, 1'b1, rows[i][23:16], 8'h00, 2'h1, rows[i][7:0]);
    end
    $display("load and table tests done");
    // Temperature bits outside the mask cannot alert
    st[3] = 8'hFF;
    repeat (3) @(negedge i_mclk);
    chk({7'h00, an}, 8'h01);
    st[0] = 8'h04;
    repeat (3) @(negedge i_mclk);
    chk({7'h00, an}, 8'h00);
    go(8'h1B, 1'b0, 8'h7A, 8'h04, 2'h0, 8'h00);
    chk({7'h00, an}, 8'h01);
    ph = 8'h00;
    go(8'h1B, 1'b0, 8'h7A, 8'h00, 2'h2, 8'h00);
    ph = 8'hFF;
    go(8'h1B, 1'b1, 8'h7A, 8'h00, 2'h1, 8'h04);
    go(8'h1B, 1'b0, 8'h7F, 8'h00, 2'h2, 8'h00);
    go(8'h20, 1'b1, 8'h7A, 8'h00, 2'h0, 8'h00);
    $display("alert and refusal tests done");
    // Mid-run reset reloads a new stored copy; read-only positions load as zero
    nvm = 40'h55_55_55_55_FB;
    @(negedge i_mclk);
    i_srst = 1'b1;
    repeat (3) @(negedge i_mclk);
    chk({rv, rj, an, 5'h00}, 8'h20);
    i_srst = 1'b0;
    go(8'h1B, 1'b1, 8'h7A, 8'h00, 2'h2, 8'h00);
    chk({7'h00, an}, 8'h00);
    go(8'h1B, 1'b1, 8'h7A, 8'h00, 2'h1, 8'hF8);
    go(8'h1B, 1'b1, 8'h7C, 8'h00, 2'h1, 8'h00);
    go(8'h1B, 1'b1, 8'h7B, 8'h00, 2'h1, 8'h10);
    go(8'h1B, 1'b1, 8'h7E, 8'h00, 2'h1, 8'h50);
    $display("mid-run reset tests done");
    results;
  end
endmodule
